// File: rtl/dla_fifo.sv
// fifo: parameterised synchronous buffer with valid/ready on both sides
`timescale 1ns/1ps
module dla_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = dla_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be power of 2");
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;
  always_comb begin
    in_ready = (wp_r - rp_r) != (AW+1)'(DEPTH);
    out_valid = wp_r != rp_r;
    out_data = mem[rp_r[AW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wp_r <= '0;
      rp_r <= '0;
    end else if (clk_en) begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      if (push) mem[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule : dla_fifo

// File: rtl/dla_gate.sv
// debug adapter link: reset gate, mode select, uart, id authentication
//
// Behaviour
// - mask board reset during a debug-mode session, forward it otherwise
// - drive target clock and separate reset out
// - mode select picks debug or programming
// - transmit on txd, receive on rxd
// - session only when ten id bytes match
// - id digit pairs map ascending from 0x70
// - link uses asynchronous uart only
`timescale 1ns/1ps
module dla_gate #(
  parameter int BAUD_DIV = dla_pkg::CLK_HZ / dla_pkg::BAUD_DEFAULT,
  parameter int CLK_DIV = dla_pkg::CLK_DIV_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic board_reset_n,
  output logic target_reset_n,
  output logic target_clk,
  output logic target_mode_select,
  input wire logic rxd,
  output logic txd,
  input wire logic session_req,
  input wire logic prog_mode,
  input wire logic [8*dla_pkg::ID_BYTES-1:0] host_id,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_valid,
  output logic cmd_ready,
  output logic [7:0] rsp_data,
  output logic rsp_valid,
  output logic session_active,
  output dla_pkg::dla_auth_t auth_status
);
  if (BAUD_DIV < 4 || CLK_DIV < 1) $error("bad divider");
  localparam int BW = $clog2(BAUD_DIV + 1);
  localparam int CW = $clog2(CLK_DIV + 1);
  // pin synchronisers
  logic [1:0] brst_s_r, rxd_s_r;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      brst_s_r <= 2'b11;
      rxd_s_r <= 2'b11;
    end else if (clk_en) begin
      brst_s_r <= {brst_s_r[0], board_reset_n};
      rxd_s_r <= {rxd_s_r[0], rxd};
    end
  end
  wire board_rst_n_s = brst_s_r[1];
  wire rxd_s = rxd_s_r[1];
  // target clock divider
  logic [CW-1:0] cdiv_r, cdiv_nxt;
  logic tclk_r, tclk_nxt;
  always_comb begin
    cdiv_nxt = cdiv_r + 1'b1;
    tclk_nxt = tclk_r;
    if (cdiv_r == CW'(CLK_DIV - 1)) begin
      cdiv_nxt = '0;
      tclk_nxt = !tclk_r;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cdiv_r <= '0;
      tclk_r <= 1'b0;
    end else if (clk_en) begin
      cdiv_r <= cdiv_nxt;
      tclk_r <= tclk_nxt;
    end
  end

  // uart transmitter, 8N1
  logic tx_go;
  logic [7:0] tx_byte;
  logic [9:0] tsh_r, tsh_nxt;
  logic [3:0] tbit_r, tbit_nxt;
  logic [BW-1:0] tcnt_r, tcnt_nxt;
  logic txd_r, txd_nxt;
  wire tx_idle = tbit_r == 4'h0;
  always_comb begin
    tsh_nxt = tsh_r;
    tbit_nxt = tbit_r;
    tcnt_nxt = tcnt_r;
    txd_nxt = txd_r;
    if (tx_idle) begin
      txd_nxt = 1'b1;
      if (tx_go) begin
        tsh_nxt = {1'b1, tx_byte, 1'b0};
        tbit_nxt = 4'd10;
        tcnt_nxt = '0;
      end
    end else if (tcnt_r == '0) begin
      txd_nxt = tsh_r[0];
      tsh_nxt = {1'b1, tsh_r[9:1]};
      tcnt_nxt = BW'(BAUD_DIV - 1);
    end else begin
      tcnt_nxt = tcnt_r - 1'b1;
      if (tcnt_r == BW'(1)) tbit_nxt = tbit_r - 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tsh_r <= '1;
      tbit_r <= '0;
      tcnt_r <= '0;
      txd_r <= 1'b1;
    end else if (clk_en) begin
      tsh_r <= tsh_nxt;
      tbit_r <= tbit_nxt;
      tcnt_r <= tcnt_nxt;
      txd_r <= txd_nxt;
    end
  end
  // uart receiver
  logic [7:0] rsh_r, rsh_nxt;
  logic [3:0] rbit_r, rbit_nxt;
  logic [BW-1:0] rcnt_r, rcnt_nxt;
  logic rx_done;
  always_comb begin
    rsh_nxt = rsh_r;
    rbit_nxt = rbit_r;
    rcnt_nxt = rcnt_r;
    rx_done = 1'b0;
    if (rbit_r == 4'h0) begin
      if (!rxd_s) begin
        rbit_nxt = 4'd10;
        rcnt_nxt = BW'(BAUD_DIV / 2); // sample mid-bit
      end
    end else if (rcnt_r != '0) begin
      rcnt_nxt = rcnt_r - 1'b1;
    end else begin
      rcnt_nxt = BW'(BAUD_DIV - 1);
      rbit_nxt = rbit_r - 1'b1;
      if (rbit_r == 4'd10 && rxd_s) rbit_nxt = 4'h0; // false start
      else if (rbit_r > 4'd1) rsh_nxt = {rxd_s, rsh_r[7:1]};
      else rx_done = rxd_s; // framing error drops byte
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rsh_r <= '0;
      rbit_r <= '0;
      rcnt_r <= '0;
    end else if (clk_en) begin
      rsh_r <= rsh_nxt;
      rbit_r <= rbit_nxt;
      rcnt_r <= rcnt_nxt;
    end
  end
  // receive buffer toward the host
  logic fifo_ov;
  logic rsp_valid_r, rsp_v_nxt;
  logic [7:0] fifo_d;
  dla_fifo #(.WIDTH(8), .DEPTH(dla_pkg::FIFO_DEPTH)) u_rx_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .in_data(rsh_r),
    .in_valid(rx_done),
    .in_ready(),
    .out_data(fifo_d),
    .out_valid(fifo_ov),
    .out_ready(!rsp_valid_r)
  );
  // session control
  typedef enum logic [2:0] {S_IDLE, S_REQ, S_RECV, S_CHECK, S_OPEN, S_FAIL}
    dla_state_t;
  dla_state_t st_r, st_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic mism_r, mism_nxt;
  logic dis_r, dis_nxt;
  logic [7:0] rsp_d_r, rsp_d_nxt;
  dla_pkg::dla_auth_t auth_r, auth_nxt;
  logic mode_r, mode_nxt;
  logic rst_r, rst_nxt;
  logic rdy_r, rdy_nxt, act_r;

  function automatic logic [7:0] id_byte(input logic [79:0] id,
                                        input logic [3:0] i);
    // first digit pair of the string sits in the top byte, at 0x70
    id_byte = id[8*(dla_pkg::ID_BYTES-1-int'(i)) +: 8];
  endfunction : id_byte

  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    mism_nxt = mism_r;
    dis_nxt = dis_r;
    auth_nxt = auth_r;
    rsp_d_nxt = rsp_d_r;
    rsp_v_nxt = 1'b0;
    tx_go = 1'b0;
    tx_byte = cmd_data;
    mode_nxt = mode_r;
    unique case (st_r)
      S_IDLE: begin
        if (session_req) begin
          mode_nxt = prog_mode;
          auth_nxt = '0;
          st_nxt = S_REQ;
        end
      end
      S_REQ: begin
        tx_byte = dla_pkg::CMD_READ_ID;
        tx_go = tx_idle;
        if (tx_idle) begin
          idx_nxt = '0;
          mism_nxt = 1'b0;
          st_nxt = S_RECV;
        end
      end
      S_RECV: begin
        if (fifo_ov) begin
          // compare stored bytes 0x70..0x79 in order
          if (fifo_d != id_byte(host_id, idx_r)) mism_nxt = 1'b1;
          if (idx_r == 4'(dla_pkg::ID_BYTES - 1)) begin
            dis_nxt = !fifo_d[dla_pkg::ENABLE_BIT];
            st_nxt = S_CHECK;
          end
          idx_nxt = idx_r + 1'b1;
        end
      end
      S_CHECK: begin
        auth_nxt.disabled = dis_r;
        if (mism_r || dis_r) begin
          auth_nxt.fail = 1'b1;
          st_nxt = S_FAIL;
        end else begin
          auth_nxt.ok = 1'b1;
          st_nxt = S_OPEN;
        end
      end
      S_OPEN: begin
        tx_go = cmd_valid && rdy_r;
        if (fifo_ov && !rsp_valid_r) begin
          rsp_d_nxt = fifo_d;
          rsp_v_nxt = 1'b1;
        end
        if (!session_req) begin
          auth_nxt = '0;
          st_nxt = S_IDLE;
        end
      end
      S_FAIL: begin
        // no command reaches the target
        if (!session_req) st_nxt = S_IDLE;
      end
      default: st_nxt = S_IDLE;
    endcase
    rst_nxt = board_rst_n_s;
    if (st_r == S_OPEN && mode_r == 1'b0) rst_nxt = 1'b1;
    // registered ready, so it only rises with the transmitter idle
    rdy_nxt = st_nxt == S_OPEN && tbit_nxt == 4'h0;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r <= S_IDLE;
      idx_r <= '0;
      mism_r <= 1'b0;
      dis_r <= 1'b0;
      auth_r <= '0;
      rsp_d_r <= '0;
      rsp_valid_r <= 1'b0;
      mode_r <= 1'b0;
      rst_r <= 1'b0;
      rdy_r <= 1'b0;
      act_r <= 1'b0;
    end else if (clk_en) begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      mism_r <= mism_nxt;
      dis_r <= dis_nxt;
      auth_r <= auth_nxt;
      rsp_d_r <= rsp_d_nxt;
      rsp_valid_r <= rsp_v_nxt;
      mode_r <= mode_nxt;
      rst_r <= rst_nxt;
      rdy_r <= rdy_nxt;
      act_r <= st_nxt == S_OPEN;
    end
  end

  always_comb begin
    target_reset_n = rst_r;
    target_clk = tclk_r;
    target_mode_select = mode_r;
    txd = txd_r;
    rsp_data = rsp_d_r;
    rsp_valid = rsp_valid_r;
    session_active = act_r;
    cmd_ready = rdy_r;
    auth_status = auth_r;
  end
endmodule : dla_gate

// File: rtl/dla_pkg.sv
// package: constants and carrier types for the debug link gate
package dla_pkg;
  localparam int ID_BYTES = 10;
  localparam logic [7:0] ID_FIRST_ADDR = 8'h70;
  localparam logic [7:0] ID_LAST_ADDR = 8'h79;
  localparam int ENABLE_BIT = 7;
  localparam int CLK_HZ = 20_000_000;
  localparam int BAUD_DEFAULT = 115_200;
  localparam int CLK_DIV_DEFAULT = 2;
  localparam int FIFO_DEPTH = 8;
  localparam logic [7:0] CMD_READ_ID = 8'h01;

  typedef struct packed {
    logic ok;
    logic fail;
    logic disabled;
  } dla_auth_t;

  typedef struct packed {
    logic rst_mask;
    logic prog_mode;
  } dla_ctrl_t;
endpackage : dla_pkg

// File: tb/dla_gate_assertions.sv
// checker: port timing of the debug link gate
`timescale 1ns/1ps
module dla_gate_assertions (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic board_reset_n,
  input wire logic target_reset_n,
  input wire logic target_mode_select,
  input wire logic txd,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic session_active,
  input wire dla_pkg::dla_auth_t auth_status
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // frame checks assume a bit time of at least 8 clocks
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_open_dbg;
    (session_active && !target_mode_select)[*4];
  endsequence
  a_reset_fwd: assert property (
    (!board_reset_n && (!session_active || target_mode_select))[*4]
    |-> !target_reset_n) else $error("board reset not forwarded");
  a_reset_mask: assert property (
    s_open_dbg |-> target_reset_n) else $error("reset leaked in session");
  a_reset_idle: assert property (
    $rose(resetn) |-> txd && !target_reset_n && !session_active)
    else $error("bad state after reset");
  a_mode_hold: assert property (
    session_active && $past(session_active) |-> $stable(target_mode_select))
    else $error("mode changed in session");
  // txd is registered, so the start bit is sampled from the second edge
  a_start_bit: assert property (
    s_take |=> ##1 (!txd)[*8]) else $error("no start bit after command");
  a_busy_frame: assert property (
    s_take |=> (!cmd_ready)[*8]) else $error("ready during frame");
  a_no_cmd: assert property (
    !session_active |-> !cmd_ready) else $error("command outside session");
  a_auth_open: assert property (
    session_active |-> auth_status.ok && !auth_status.fail)
    else $error("session without match");
endmodule : dla_gate_assertions

bind dla_gate dla_gate_assertions u_chk (.sys_clk(sys_clk),
  .resetn(resetn), .board_reset_n(board_reset_n),
  .target_reset_n(target_reset_n), .target_mode_select(target_mode_select),
  .txd(txd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .session_active(session_active), .auth_status(auth_status));

// File: tb/dla_target_model.sv
// partner: target uart that answers id requests and returns each command byte inverted
`timescale 1ns/1ps
module dla_target_model #(
  parameter int BIT = 8
) (
  input wire logic sys_clk,
  input wire logic txd,
  output logic rxd,
  input wire logic [79:0] id,
  input wire logic [7:0] gap
);
  logic [7:0] b;
  task automatic get(output logic [7:0] v);
    @(negedge txd);
    repeat (BIT / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge sys_clk);
      v[i] = txd;
    end
    repeat (BIT) @(posedge sys_clk);
  endtask : get
  task automatic put(input logic [7:0] v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge sys_clk);
    end
  endtask : put
  initial begin
    rxd = 1'b1;
    forever begin
      get(b);
      // slow answers stretch the wait on purpose
      repeat (gap) @(posedge sys_clk);
      if (b == dla_pkg::CMD_READ_ID)
        for (int k = 9; k >= 0; k--) put(id[8*k +: 8]);
      else
        put(~b);
    end
  end
endmodule : dla_target_model

// File: tb/test_dla_gate.sv
// testbench: id sessions, commands and reset gating of the debug link
`timescale 1ns/1ps
module test_dla_gate;
  localparam int BD = 8;
  logic sys_clk, resetn, board_reset_n, session_req, prog_mode;
  logic target_reset_n, target_clk, target_mode_select, rxd, txd;
  logic cmd_valid, cmd_ready, rsp_valid, session_active;
  logic clk_en;
  logic [79:0] host_id, stored_id, id;
  logic [7:0] cmd_data, rsp_data, gap;
  logic [2:0] exp_auth;
  dla_pkg::dla_auth_t auth_status;
  int errors = 0, check_count = 0, cycles = 0;
  logic [7:0] pend[$];

  dla_gate #(.BAUD_DIV(BD)) u_dut (.sys_clk(sys_clk), .resetn(resetn),
    .clk_en(clk_en), .board_reset_n(board_reset_n),
    .target_reset_n(target_reset_n), .target_clk(target_clk),
    .target_mode_select(target_mode_select), .rxd(rxd), .txd(txd),
    .session_req(session_req), .prog_mode(prog_mode), .host_id(host_id),
    .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .session_active(session_active), .auth_status(auth_status));
  dla_target_model #(.BIT(BD)) u_tgt (.sys_clk(sys_clk), .txd(txd),
    .rxd(rxd), .id(stored_id), .gap(gap));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : tick

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected value at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      final_report();
    end
  end

  task automatic send_cmd();
    int n = 0;
    while (cmd_ready !== 1'b1 && n++ < 500) tick(1);
    cmd_data = 8'($urandom) | 8'h80;
    pend.push_back(~cmd_data);
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n++ < 2000) tick(1);
    chk_byte(rsp_data, pend.pop_front());
  endtask : send_cmd

  task automatic session(input logic [79:0] hid, input logic [79:0] sid,
    input logic mode);
    int n = 0;
    logic v;
    host_id = hid;
    stored_id = sid;
    prog_mode = mode;
    gap = 8'($urandom_range(0, 40));
    exp_auth[2] = (hid == sid) && sid[7];
    exp_auth[1] = !exp_auth[2];
    exp_auth[0] = !sid[7];
    session_req = 1'b1;
    // a failed session keeps its status until the next request is taken
    tick(1);
    while (auth_status === 3'b000 && n++ < 3000) tick(1);
    tick(2);
    chk_byte(8'(auth_status), 8'(exp_auth));
    chk_byte(8'(session_active), 8'(exp_auth[2]));
    chk_byte(8'(target_mode_select), 8'(mode));
    v = target_clk;
    tick(dla_pkg::CLK_DIV_DEFAULT);
    chk_byte(8'(target_clk), 8'(!v));
    if (exp_auth[2]) begin
      repeat (3) send_cmd();
    end else begin
      tick(100);
      chk_byte(8'(cmd_ready), 8'h00);
    end
    board_reset_n = 1'b0;
    tick(5);
    chk_byte(8'(target_reset_n), 8'(exp_auth[2] && !mode));
    board_reset_n = 1'b1;
    tick(5);
    chk_byte(8'(target_reset_n), 8'h01);
    v = target_clk;
    clk_en = 1'b0;
    session_req = 1'b0;
    tick(5);
    chk_byte(8'(session_active), 8'(exp_auth[2]));
    chk_byte(8'(target_clk), 8'(v));
    clk_en = 1'b1;
    tick(5);
    chk_byte(8'(session_active), 8'h00);
  endtask : session

  initial begin
    resetn = 1'b0;
    board_reset_n = 1'b1;
    session_req = 1'b0;
    prog_mode = 1'b0;
    clk_en = 1'b1;
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    host_id = '0;
    stored_id = '0;
    gap = 8'h00;
    void'($urandom(15));
    tick(2);
    resetn = 1'b1;
    for (int k = 0; k < 5; k++) begin
      id = {$urandom, $urandom, 16'($urandom)} | 80'h80;
      case (k)
        0: session(id, id, 1'b0);
        1: session(id, id, 1'b1);
        2: session(id ^ (80'h1 << (8 * $urandom_range(0, 9))), id, 1'b0);
        3: session(id & ~80'h80, id & ~80'h80, 1'b0);
        default: session(80'h1234_5678_9abc_def1_23d4,
          80'h1234_5678_9abc_def1_23d4, 1'b0);
      endcase
    end
    final_report();
  end
endmodule : test_dla_gate
